// ===== sdp_top.sv
// divider chain and load interface of an integer-n synthesizer
// Behaviour
// - prescaler enabled divides by ten or eleven
// - prescaler disabled: bypass and power it down
// - main ratio is ten times (m+1) plus a, for a up to m+1
// - nine-bit main counter with modulus select
// - bypassed, main count one gives ratio two
// - reference divided by programmed count plus one
// - reference count zero passes reference through
// - mode pins pick parallel, serial or direct
// - parallel strobes capture data into sections
// - fixed bit order for sections and serial
// - parallel hop strobe copies primary to secondary
// - parallel bank select picks primary or secondary
// - parallel feature strobe captures feature byte
// - feature bits act only while enable low
// - serial shifts twenty setting bits, b0 first
// - serial or hop strobe copies primary
// - serial bank select picks primary or secondary
// - serial shifts eight feature bits, b0 first
// - feature buffer loads on feature strobe fall
// - fixed feature bit order
// - direct mode takes counts from pins
// - direct mode forces top count bits zero
// - power down stops all but programming
// - counter load bit loads settings continuously
// - diagnostic pin shows modulus select or prescaler
`timescale 1ns/1ps
module sdp_top (
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic       rf_in_i,
  input  wire logic       ref_in_i,
  input  wire logic       serial_clock_i,
  input  wire logic       serial_data_i,
  input  wire logic [7:0] data_i,
  input  wire logic       main_high_write_strobe_i,
  input  wire logic       main_low_write_strobe_i,
  input  wire logic       swallow_write_strobe_i,
  input  wire logic       hop_write_strobe_i,
  input  wire logic       feature_write_strobe_i,
  input  wire logic       serial_write_strobe_i,
  input  wire logic       bus_mode_i,
  input  wire logic       shift_mode_i,
  input  wire logic       prescaler_en_n_i,
  input  wire logic       feature_en_n_i,
  input  wire logic       parallel_bank_select_i,
  input  wire logic       serial_bank_select_i,
  input  wire logic [6:0] direct_main_i,
  input  wire logic [3:0] direct_ref_i,
  input  wire logic [3:0] direct_swallow_i,
  output logic            main_div_o,
  output logic            comp_div_o,
  output logic            diag_o,
  output logic            prescaler_off_o
);
  logic [`SDP_SYNC_W-1:0] async_in;
  logic [`SDP_SYNC_W-1:0] sync_out;
  logic [`SDP_SYNC_W-1:0] prev_r;
  logic [`SDP_SYNC_W-1:0] rise;
  logic [`SDP_SYNC_W-1:0] fall;

  logic       rf_s, ref_s, sck_s, sd_s;
  logic [7:0] d_s;
  logic       mh_s, ml_s, sw_s, hop_s, fw_s, srw_s;
  logic       bm_s, sm_s, pre_n_s, fen_n_s, parallel_bank_select_s, serial_bank_select_s;
  logic [6:0] dm_s;
  logic [3:0] dr_s, da_s;

  logic rf_rise, ref_rise, sck_rise;
  logic mh_rise, ml_rise, sw_rise, hop_rise, fw_rise, fw_fall, srw_rise;

  assign async_in = {rf_in_i, ref_in_i, serial_clock_i, serial_data_i,
                     data_i, main_high_write_strobe_i,
                     main_low_write_strobe_i, swallow_write_strobe_i,
                     hop_write_strobe_i, feature_write_strobe_i,
                     serial_write_strobe_i, bus_mode_i, shift_mode_i,
                     prescaler_en_n_i, feature_en_n_i,
                     parallel_bank_select_i, serial_bank_select_i,
                     direct_main_i, direct_ref_i, direct_swallow_i};

  sdp_sync #(
    .W      (`SDP_SYNC_W)
  ) u_sync (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .async_i(async_in),
    .sync_o (sync_out)
  );

  assign {rf_s, ref_s, sck_s, sd_s, d_s, mh_s, ml_s, sw_s, hop_s, fw_s,
          srw_s, bm_s, sm_s, pre_n_s, fen_n_s, parallel_bank_select_s, serial_bank_select_s,
          dm_s, dr_s, da_s} = sync_out;

  // edges of the synchronised pins
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prev_r <= '0;
    end else begin
      prev_r <= sync_out;
    end
  end

  assign rise = sync_out & ~prev_r;
  assign fall = ~sync_out & prev_r;
  assign {rf_rise, ref_rise, sck_rise} = rise[38:36];
  assign {mh_rise, ml_rise, sw_rise, hop_rise, fw_rise} = rise[26:22];
  assign srw_rise = rise[21];
  assign fw_fall  = fall[22];

  function automatic sdp_pkg::sdp_mode_e mode_of(input logic bm,
                                                 input logic sm);
    if (bm) begin
      return sdp_pkg::SDP_DIRECT;
    end else if (sm) begin
      return sdp_pkg::SDP_SERIAL;
    end
    return sdp_pkg::SDP_PARALLEL;
  endfunction

  sdp_pkg::sdp_mode_e mode;
  assign mode = mode_of(bm_s, sm_s);

  // programming registers
  sdp_pkg::sdp_cfg_t  prim_r, prim_nxt;
  sdp_pkg::sdp_cfg_t  sec_r, sec_nxt;
  sdp_pkg::sdp_feat_t feat_r, feat_nxt;
  sdp_pkg::sdp_feat_t fsh_r, fsh_nxt;

  always_comb begin
    prim_nxt = prim_r;
    sec_nxt  = sec_r;
    feat_nxt = feat_r;
    fsh_nxt  = fsh_r;
    unique case (mode)
      sdp_pkg::SDP_PARALLEL: begin
        if (mh_rise) begin
          prim_nxt[`SDP_S_HI] = d_s[3:0];
        end
        if (ml_rise) begin
          prim_nxt[`SDP_S_MID] = d_s;
        end
        if (sw_rise) begin
          prim_nxt[`SDP_S_LO] = d_s;
        end
        if (hop_rise) begin
          sec_nxt = prim_r;
        end
        if (fw_rise) begin
          feat_nxt = d_s;
        end
      end
      sdp_pkg::SDP_SERIAL: begin
        if (sck_rise && !srw_s) begin
          if (fw_s) begin
            fsh_nxt = {fsh_r[6:0], sd_s};
          end else begin
            prim_nxt = {prim_r[18:0], sd_s};
          end
        end
        if (srw_rise || hop_rise) begin
          sec_nxt = prim_r;
        end
        if (fw_fall) begin
          feat_nxt = fsh_r;
        end
      end
      sdp_pkg::SDP_DIRECT: begin
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prim_r <= `SDP_CFG_RST;
      sec_r  <= `SDP_CFG_RST;
      feat_r <= `SDP_FEAT_RST;
      fsh_r  <= `SDP_FEAT_RST;
    end else begin
      prim_r <= prim_nxt;
      sec_r  <= sec_nxt;
      feat_r <= feat_nxt;
      fsh_r  <= fsh_nxt;
    end
  end

  // divider chain
  sdp_pkg::sdp_feat_t feat_act;
  sdp_pkg::sdp_cfg_t  sel_cfg;
  sdp_pkg::sdp_cfg_t  act_r, act_nxt;
  logic [3:0] presc_r, presc_nxt;
  logic [8:0] main_r, main_nxt;
  logic [3:0] swal_r, swal_nxt;
  logic [5:0] ref_r, ref_nxt;
  logic       fp_r, fp_nxt;
  logic       fc_r, fc_nxt;
  logic       mdo_nxt, cdo_nxt, diag_nxt, poff_nxt;
  logic       pd, oe_off, bypass, modulus_select, tick;
  logic [8:0] act_m;
  logic [5:0] act_rr;

  assign feat_act = fen_n_s ? `SDP_FEAT_RST : feat_r;
  assign pd       = feat_act[`SDP_FB_PD];
  assign oe_off   = feat_act[`SDP_FB_OE];
  assign bypass   = act_r[`SDP_F_PRE];
  assign act_m    = {act_r[`SDP_F_MHI], act_r[`SDP_F_MLO]};
  assign act_rr   = {act_r[`SDP_F_RHI], act_r[`SDP_F_RLO]};
  assign modulus_select     = (swal_r != 4'h0) && !bypass;

  always_comb begin
    unique case (mode)
      sdp_pkg::SDP_DIRECT: begin
        sel_cfg = `SDP_CFG_RST;
        sel_cfg[`SDP_F_PRE] = pre_n_s;
        sel_cfg[`SDP_F_MLO] = dm_s;
        sel_cfg[`SDP_F_RLO] = dr_s;
        sel_cfg[`SDP_F_SWL] = da_s;
      end
      sdp_pkg::SDP_SERIAL: begin
        sel_cfg = serial_bank_select_s ? prim_r : sec_r;
      end
      sdp_pkg::SDP_PARALLEL: begin
        sel_cfg = parallel_bank_select_s ? prim_r : sec_r;
      end
    endcase
  end

  always_comb begin
    act_nxt   = act_r;
    presc_nxt = presc_r;
    main_nxt  = main_r;
    swal_nxt  = swal_r;
    ref_nxt   = ref_r;
    fp_nxt    = fp_r;
    fc_nxt    = fc_r;
    tick      = 1'b0;
    if (feat_act[`SDP_FB_LOAD]) begin
      act_nxt = sel_cfg;
    end
    if (!pd) begin
      if (rf_rise) begin
        fp_nxt = 1'b0;
        // eleven while swallowing, else ten
        tick = bypass ||
               (presc_r == (modulus_select ? `SDP_TC_ELEVEN : `SDP_TC_TEN));
        presc_nxt = (bypass || tick) ? 4'h0 : 4'(presc_r + 4'h1);
        if (tick) begin
          if (main_r >= act_m) begin
            main_nxt = 9'h000;
            fp_nxt   = 1'b1;
            act_nxt  = sel_cfg;
            swal_nxt = sel_cfg[`SDP_F_SWL];
          end else begin
            main_nxt = 9'(main_r + 9'h001);
            if (swal_r != 4'h0) begin
              swal_nxt = 4'(swal_r - 4'h1);
            end
          end
        end
      end
      if (ref_rise) begin
        if (ref_r >= act_rr) begin
          ref_nxt = 6'h00;
          fc_nxt  = 1'b1;
        end else begin
          ref_nxt = 6'(ref_r + 6'h01);
          fc_nxt  = 1'b0;
        end
      end
    end
    mdo_nxt  = fp_nxt && !oe_off && !pd;
    cdo_nxt  = ((act_rr == 6'h00) ? ref_s : fc_nxt)
               && !oe_off && !pd;
    poff_nxt = bypass || pd;
    if (pd) begin
      diag_nxt = 1'b0;
    end else if (feat_act[`SDP_FB_PRES]) begin
      diag_nxt = (presc_r == 4'h0) && !bypass;
    end else if (feat_act[`SDP_FB_MODULUS_SELECT]) begin
      diag_nxt = modulus_select;
    end else begin
      diag_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      act_r           <= `SDP_CFG_RST;
      presc_r         <= 4'h0;
      main_r          <= 9'h000;
      swal_r          <= 4'h0;
      ref_r           <= 6'h00;
      fp_r            <= 1'b0;
      fc_r            <= 1'b0;
      main_div_o      <= 1'b0;
      comp_div_o      <= 1'b0;
      diag_o          <= 1'b0;
      prescaler_off_o <= 1'b0;
    end else begin
      act_r           <= act_nxt;
      presc_r         <= presc_nxt;
      main_r          <= main_nxt;
      swal_r          <= swal_nxt;
      ref_r           <= ref_nxt;
      fp_r            <= fp_nxt;
      fc_r            <= fc_nxt;
      main_div_o      <= mdo_nxt;
      comp_div_o      <= cdo_nxt;
      diag_o          <= diag_nxt;
      prescaler_off_o <= poff_nxt;
    end
  end

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_par;
    mode == sdp_pkg::SDP_PARALLEL;
  endsequence

  sequence s_ser_shift;
    mode == sdp_pkg::SDP_SERIAL && sck_rise && !srw_s && !fw_s;
  endsequence

  sequence s_feat_fall;
    mode == sdp_pkg::SDP_SERIAL && fw_fall;
  endsequence

  property p_main_high_load;
    s_par and (mh_rise && !sw_rise) |=>
      prim_r[`SDP_S_HI] == $past(d_s[3:0]);
  endproperty
  a_main_high_load: assert property (p_main_high_load)
    else $error("main high section not captured");

  property p_hop_copy;
    s_par and hop_rise |=> sec_r == $past(prim_r);
  endproperty
  a_hop_copy: assert property (p_hop_copy)
    else $error("hop strobe did not copy primary");

  property p_serial_shift;
    s_ser_shift |=> prim_r == {$past(prim_r[18:0]), $past(sd_s)};
  endproperty
  a_serial_shift: assert property (p_serial_shift)
    else $error("serial setting shift wrong");

  property p_feat_buffer;
    s_feat_fall |=> feat_r == $past(fsh_r) ##1 $stable(feat_r);
  endproperty
  a_feat_buffer: assert property (p_feat_buffer)
    else $error("feature buffer not loaded on strobe fall");

  property p_direct_zero;
    mode == sdp_pkg::SDP_DIRECT |->
      sel_cfg[`SDP_S_HI] == 4'h0 && sel_cfg[`SDP_F_MLO] == dm_s;
  endproperty
  a_direct_zero: assert property (p_direct_zero)
    else $error("direct mode top bits not forced low");

  property p_par_bank;
    s_par and parallel_bank_select_s |-> sel_cfg == prim_r;
  endproperty
  a_par_bank: assert property (p_par_bank)
    else $error("parallel bank select ignored");

  property p_oe_off;
    oe_off |=> !main_div_o && !comp_div_o;
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("divided outputs active while disabled");

  property p_pd_halt;
    pd |=> $stable(main_r) && $stable(ref_r) && !diag_o;
  endproperty
  a_pd_halt: assert property (p_pd_halt)
    else $error("counters run during power down");

  property p_ref_pass;
    act_rr == 6'h00 && !pd && !oe_off |=> comp_div_o == $past(ref_s);
  endproperty
  a_ref_pass: assert property (p_ref_pass)
    else $error("reference not passed through");

  property p_eleven;
    !pd && rf_rise && modulus_select && presc_r == `SDP_TC_TEN |=>
      presc_r == `SDP_TC_ELEVEN;
  endproperty
  a_eleven: assert property (p_eleven)
    else $error("prescaler did not divide by eleven");

  property p_cnt_load;
    feat_act[`SDP_FB_LOAD] |=> act_r == $past(sel_cfg);
  endproperty
  a_cnt_load: assert property (p_cnt_load)
    else $error("counter load bit did not load settings");
endmodule

// ===== sdp_defines.svh
// constants for the synthesizer divider programming block
`ifndef SDP_DEFINES_SVH
`define SDP_DEFINES_SVH

`define SDP_CFG_W      20
`define SDP_FEAT_W     8
`define SDP_SYNC_W     39

// counter setting layout, bit 19 is serial bit B0
`define SDP_F_RHI      19:18
`define SDP_F_MHI      17:16
`define SDP_F_PRE      15
`define SDP_F_MLO      14:8
`define SDP_F_RLO      7:4
`define SDP_F_SWL      3:0

// parallel write sections
`define SDP_S_HI       19:16
`define SDP_S_MID      15:8
`define SDP_S_LO       7:0

// feature bits, bit 7 is serial bit B0
`define SDP_FB_PD      4
`define SDP_FB_LOAD    3
`define SDP_FB_MODULUS_SELECT    2
`define SDP_FB_PRES    1
`define SDP_FB_OE      0

// prescaler terminal counts for divide by ten and eleven
`define SDP_TC_TEN     4'h9
`define SDP_TC_ELEVEN  4'ha

`define SDP_CFG_RST    20'h00000
`define SDP_FEAT_RST   8'h00

`endif

// ===== sdp_pkg.sv
// types for the synthesizer divider programming block
`include "sdp_defines.svh"
package sdp_pkg;
  typedef enum logic [1:0] {
    SDP_PARALLEL,
    SDP_SERIAL,
    SDP_DIRECT
  } sdp_mode_e;
  typedef logic [`SDP_CFG_W-1:0]  sdp_cfg_t;
  typedef logic [`SDP_FEAT_W-1:0] sdp_feat_t;
endpackage

// ===== sdp_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module sdp_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rstn_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] sync_nxt;

  always_comb begin
    meta_nxt = async_i;
    sync_nxt = meta_r;
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_r <= '0;
      sync_o <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_o <= sync_nxt;
    end
  end
endmodule

// ===== sdp_host_model.sv
// host model driving the programming pins of the divider block
`timescale 1ns/1ps
module sdp_host_model (
  input  wire logic       clk_i,
  output logic      [7:0] data_o,
  output logic            main_high_write_strobe_o,
  output logic            main_low_write_strobe_o,
  output logic            swallow_write_strobe_o,
  output logic            hop_write_strobe_o,
  output logic            feature_write_strobe_o,
  output logic            serial_write_strobe_o,
  output logic            serial_clock_o,
  output logic            serial_data_o
);
  logic [5:0] strb;
  int         slow;
  assign main_high_write_strobe_o = strb[0];
  assign main_low_write_strobe_o  = strb[1];
  assign swallow_write_strobe_o   = strb[2];
  assign hop_write_strobe_o       = strb[3];
  assign feature_write_strobe_o   = strb[4];
  assign serial_write_strobe_o    = strb[5];
  initial begin
    strb = 6'h00;
    data_o = 8'h00;
    serial_clock_o = 1'b0;
    serial_data_o = 1'b0;
    slow = 0;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // data set up before the rise and held well after it
  task automatic pulse(input int idx, input logic [7:0] d);
    data_o = d;
    step(4 + slow);
    strb[idx] = 1'b1;
    step(6 + slow);
    strb[idx] = 1'b0;
    step(2);
    data_o = ~d; // released bus no longer shows the byte
    step(4 + slow);
  endtask
  task automatic level(input int idx, input logic v);
    strb[idx] = v;
    step(8);
  endtask
  // bit n-1 of the word leaves first; clock stands low between frames
  task automatic shift(input logic [19:0] w, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      serial_data_o = w[i];
      step(4);
      serial_clock_o = 1'b1;
      step(12);
      serial_clock_o = 1'b0;
      serial_data_o = ~w[i];
      step(9);
    end
    step(6);
  endtask
endmodule

// ===== tb_sdp_top.sv
// self-checking bench for the divider programming block
`timescale 1ns/1ps
module tb_sdp_top;
  logic       clk_i;
  logic       rstn_i;
  logic       rf_in;
  logic       ref_in;
  logic       bus_mode;
  logic       shift_mode;
  logic       pre_en_n;
  logic       feat_en_n;
  logic       pbs;
  logic       sbs;
  logic [6:0] dir_m;
  logic [3:0] dir_r;
  logic [3:0] dir_a;
  logic [7:0] data;
  logic [5:0] st;
  logic       sclk;
  logic       sdata;
  logic [3:0] outs;
  int         num_errors;
  int         checked;
  int         cnt [2];

  sdp_host_model sdp_host_model_i (
    .clk_i(clk_i), .data_o(data),
    .main_high_write_strobe_o(st[0]), .main_low_write_strobe_o(st[1]),
    .swallow_write_strobe_o(st[2]), .hop_write_strobe_o(st[3]),
    .feature_write_strobe_o(st[4]), .serial_write_strobe_o(st[5]),
    .serial_clock_o(sclk), .serial_data_o(sdata)
  );
  sdp_top sdp_top_i (
    .clk_i(clk_i), .rstn_i(rstn_i), .rf_in_i(rf_in), .ref_in_i(ref_in),
    .serial_clock_i(sclk), .serial_data_i(sdata), .data_i(data),
    .main_high_write_strobe_i(st[0]), .main_low_write_strobe_i(st[1]),
    .swallow_write_strobe_i(st[2]), .hop_write_strobe_i(st[3]),
    .feature_write_strobe_i(st[4]), .serial_write_strobe_i(st[5]),
    .bus_mode_i(bus_mode), .shift_mode_i(shift_mode),
    .prescaler_en_n_i(pre_en_n), .feature_en_n_i(feat_en_n),
    .parallel_bank_select_i(pbs), .serial_bank_select_i(sbs),
    .direct_main_i(dir_m), .direct_ref_i(dir_r), .direct_swallow_i(dir_a),
    .main_div_o(outs[0]), .comp_div_o(outs[1]), .diag_o(outs[2]),
    .prescaler_off_o(outs[3])
  );

  initial clk_i = 1'b0;
  always #2.5 clk_i = ~clk_i;
  // rf every 8 clocks, reference every 6 clocks
  always begin
    repeat (4) @(posedge clk_i);
    #1;
    rf_in = ~rf_in;
    if (rf_in) cnt[0]++;
  end
  always begin
    repeat (3) @(posedge clk_i);
    #1;
    ref_in = ~ref_in;
    if (ref_in) cnt[1]++;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic fail(input string msg);
    num_errors++;
    $display("Error at %0t: %s", $time, msg);
  endtask
  task automatic check_ratio(input int got, input int exp);
    checked++;
    if (got != exp) fail($sformatf("ratio %0d, expected %0d", got, exp));
  endtask
  task automatic check_flag(input logic got, input logic exp);
    checked++;
    if (got !== exp) fail($sformatf("flag %b, expected %b", got, exp));
  endtask
  task automatic wait_rise(input int w);
    logic p;
    int   k;
    p = outs[w];
    for (k = 0; k < 1000; k++) begin
      @(posedge clk_i);
      #2;
      if (outs[w] === 1'b1 && p !== 1'b1) break;
      p = outs[w];
    end
    if (k == 1000) fail("no divided pulse");
  endtask
  // input edges between two output rises after the chain settles
  task automatic ratio(input int w, input int exp);
    int c0;
    wait_rise(w);
    wait_rise(w);
    c0 = cnt[w];
    wait_rise(w);
    check_ratio(cnt[w] - c0, exp);
  endtask
  // whether an output goes high in a window after a settling time
  task automatic seen(input int w, input logic exp);
    logic s;
    s = 1'b0;
    tick(40);
    repeat (800) begin
      @(posedge clk_i);
      #2;
      if (outs[w] === 1'b1) s = 1'b1;
    end
    check_flag(s, exp);
  endtask
  task automatic wr(input int s, input logic [7:0] d);
    sdp_host_model_i.pulse(s, d);
  endtask
  task automatic sh(input logic [19:0] w, input int n);
    sdp_host_model_i.shift(w, n);
  endtask
  task automatic wrap_up;
    if (num_errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    #400us;
    fail("watchdog expired");
    wrap_up();
  end

  initial begin
    logic [7:0] feat [3];
    num_errors = 0;
    checked = 0;
    cnt[0] = 0;
    cnt[1] = 0;
    {rstn_i, rf_in, ref_in, bus_mode, shift_mode, pre_en_n} = 6'h00;
    {feat_en_n, pbs, sbs} = 3'b111;
    {dir_m, dir_r, dir_a} = 15'h0000;
    feat = '{8'h04, 8'h02, 8'h00};
    tick(8);
    rstn_i = 1'b1;
    tick(4);
    // parallel, primary bank: m=3 a=2 r=2, reserved bits zero
    wr(0, 8'h00);
    wr(1, 8'h03);
    wr(2, 8'h22);
    ratio(0, 42);
    ratio(1, 3);
    wr(1, 8'h01);
    wr(2, 8'h00);
    ratio(0, 20);
    ratio(1, 1);
    wr(3, 8'h00);
    tick(1);
    pbs = 1'b0;
    wr(1, 8'h85);
    ratio(0, 20);
    check_flag(outs[3], 1'b0);
    pbs = 1'b1;
    ratio(0, 6);
    check_flag(outs[3], 1'b1);
    wr(1, 8'h03);
    wr(2, 8'h22);
    // feature register in parallel mode
    feat_en_n = 1'b0;
    wr(4, 8'h10);
    seen(0, 1'b0);
    check_flag(outs[3], 1'b1);
    wr(4, 8'h01);
    seen(0, 1'b0);
    seen(1, 1'b0);
    for (int i = 0; i < 3; i++) begin
      wr(4, feat[i]);
      seen(2, i < 2);
    end
    wr(4, 8'h08);
    ratio(0, 42);
    wr(4, 8'h10);
    feat_en_n = 1'b1;
    seen(0, 1'b1);
    wr(4, 8'h00);
    // serial mode: m=2 a=1 r=1, then m=1 a=2 r=0, slow host
    shift_mode = 1'b1;
    sdp_host_model_i.slow = 3;
    tick(4);
    sh(20'h00211, 20);
    wr(5, 8'h00);
    sbs = 1'b0;
    ratio(0, 31);
    ratio(1, 2);
    sh(20'h00102, 20);
    ratio(0, 31);
    sbs = 1'b1;
    ratio(0, 22);
    wr(3, 8'h00);
    tick(1);
    sbs = 1'b0;
    ratio(0, 22);
    // serial feature byte stays buffered until the strobe falls
    feat_en_n = 1'b0;
    sdp_host_model_i.level(4, 1'b1);
    sh(20'h00001, 8);
    seen(0, 1'b1);
    sdp_host_model_i.level(4, 1'b0);
    seen(0, 1'b0);
    // direct mode with all top primary bits set beforehand
    shift_mode = 1'b0;
    pbs = 1'b1;
    tick(4);
    wr(0, 8'h0f);
    feat_en_n = 1'b1;
    bus_mode = 1'b1;
    dir_m = 7'h04;
    dir_a = 4'h1;
    dir_r = 4'h2;
    ratio(0, 51);
    ratio(1, 3);
    wrap_up();
  end
endmodule
